// File: lai_pkg.sv
// lai_pkg: register map, field positions, reset values and carrier types for the
// line alarm interrupt mask block.
// assumes a 32-bit apb slave with 8-bit registers in the low byte of each word.
package lai_pkg;

   // ***************************************************************
   // register indices and byte addresses
   // ***************************************************************
   // printed offsets are not word aligned: they are indices, byte address is 4x
   localparam logic [7:0]  IDX_ENABLE_A   = 8'h33;
   localparam logic [7:0]  IDX_ENABLE_B   = 8'h34;
   localparam logic [7:0]  IDX_EDGE_SEL   = 8'h35;
   localparam logic [7:0]  IDX_STATUS     = 8'h36;
   localparam int          ADDR_W         = 10;
   localparam logic [9:0]  ADDR_ENABLE_A  = {IDX_ENABLE_A, 2'b00};
   localparam logic [9:0]  ADDR_ENABLE_B  = {IDX_ENABLE_B, 2'b00};
   localparam logic [9:0]  ADDR_EDGE_SEL  = {IDX_EDGE_SEL, 2'b00};
   localparam logic [9:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};

   // ***************************************************************
   // field layout
   // ***************************************************************
   localparam int          REG_W          = 8;
   localparam int          FLAG_N         = 7;
   localparam int          EVT_B_N        = 7;
   localparam logic [7:0]  WRITE_MASK     = 8'h7F;
   localparam logic [7:0]  RESET_VAL      = 8'h00;
   localparam int          BIT_LOOP_ACT   = 6;
   localparam int          BIT_LOOP_DEACT = 5;
   localparam int          BIT_PAT_SYNC   = 4;
   localparam int          BIT_TX_CLK     = 3;
   localparam int          BIT_DRV_FAULT  = 2;
   localparam int          BIT_ALARM_IND  = 1;
   localparam int          BIT_SIG_ABSENT = 0;

   // ***************************************************************
   // timing
   // ***************************************************************
   // transmit clock must stay still for more than this many clock cycles
   localparam int          TX_CLK_LOSS_CYCLES = 70;
   localparam int          TX_CLK_CNT_W       = 7;
   localparam logic [6:0]  TX_CLK_LOSS_LIMIT  = 7'(TX_CLK_LOSS_CYCLES);

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef struct packed {
      logic loop_activate_seen_flag;
      logic loop_deactivate_seen_flag;
      logic pattern_sync_flag;
      logic tx_clock_absent_flag;
      logic driver_fault_flag;
      logic alarm_indication_flag;
      logic rx_signal_absent_flag;
   } lai_flags_t;

   typedef struct packed {
      logic shaper_overflow;
      logic tx_jitter_buffer;
      logic rx_jitter_buffer;
      logic pattern_error;
      logic excess_zeros;
      logic code_violation;
      logic counter_overflow;
   } lai_events_b_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } lai_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } lai_apb_rsp_t;

endpackage

// File: lai_line_alarm_irq_mask.sv
// lai_line_alarm_irq_mask: two interrupt enable registers, an edge select register,
// tx clock loss detection and per-source event qualification for one channel.
// assumes raw status flags and one-cycle event pulses synchronous to clock_i.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - bit 6 enable A gates loop activate
// - bit 5 enable A gates loop deactivate
// - bit 4 enable A gates pattern sync
// - bit 3 enable A gates tx clock loss
// - bit 2 enable A gates driver fault
// - bit 1 enable A gates alarm indication
// - bit 0 enable A gates signal loss
// - bit 6 enable B gates shaper overflow
// - bit 5 enable B gates tx jitter buffer
// - bit 4 enable B gates rx jitter buffer
// - bit 3 enable B gates pattern error
// - bit 2 enable B gates excess zeros
// - bit 1 enable B gates code violation
// - bit 0 enable B gates counter overflow
// - edge bit 6: loop activate rise/any
// - edge bit 5: loop deactivate rise/any
// - edge bit 4: pattern sync rise/any
// - edge bit 3: tx clock loss rise/any
// - edge bit 2: driver fault rise/any
// - edge bit 1: alarm indication rise/any
// - edge bit 0: signal loss rise/any
// - tx clock idle over 70 cycles flags
module lai_line_alarm_irq_mask (
   // clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic                  clk_en_i,
   // apb slave
   input  wire lai_pkg::lai_apb_req_t apb_req_i,
   output lai_pkg::lai_apb_rsp_t      apb_rsp_o,
   // status sources
   input  wire lai_pkg::lai_flags_t   flags_i,
   input  wire logic                  transmit_clock_input_i,
   input  wire lai_pkg::lai_events_b_t events_b_i,
   // qualified events
   output lai_pkg::lai_flags_t        flag_events_o,
   output lai_pkg::lai_events_b_t     events_b_o,
   output logic                       any_event_o,
   output lai_pkg::lai_flags_t        line_status_o
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [7:0]             enable_a;
      logic [7:0]             enable_b;
      logic [7:0]             edge_sel;
      logic [7:0]             rdata;
      lai_pkg::lai_flags_t    flags_prev;
      lai_pkg::lai_flags_t    flag_evt;
      lai_pkg::lai_events_b_t evt_b;
      logic                   tx_clk_prev;
      logic [6:0]             tx_clk_idle;
      logic                   tx_clk_absent;
   } lai_state_t;

   lai_state_t          state_q;
   lai_state_t          state_d;
   lai_pkg::lai_flags_t flags_now;
   logic [9:0]          word_addr;
   logic                access;
   logic                mapped;

   // one shared decode for reads and writes
   function automatic logic addr_hit(input logic [9:0] a);
      addr_hit = (a == lai_pkg::ADDR_ENABLE_A) || (a == lai_pkg::ADDR_ENABLE_B)
              || (a == lai_pkg::ADDR_EDGE_SEL) || (a == lai_pkg::ADDR_STATUS);
   endfunction

   // rising edge counts when enabled; falling edge only when any-edge is also set
   function automatic logic edge_event(input logic now, input logic prev,
                                       input logic any_edge, input logic en);
      edge_event = en && ((now && !prev) || (any_edge && !now && prev));
   endfunction

   // reserved bit 7 is dropped before it can be stored
   function automatic logic [7:0] write_value(input logic [31:0] wdata);
      write_value = wdata[lai_pkg::REG_W-1:0] & lai_pkg::WRITE_MASK;
   endfunction

   always_comb begin
      flags_now                      = flags_i;
      flags_now.tx_clock_absent_flag = state_q.tx_clk_absent;
   end

   assign word_addr = apb_req_i.paddr[lai_pkg::ADDR_W-1:0];
   assign access    = apb_req_i.psel && apb_req_i.penable;
   assign mapped    = addr_hit(word_addr) && (apb_req_i.paddr[31:lai_pkg::ADDR_W] == '0);

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      state_d = state_q;

      // register writes, reserved bit 7 dropped
      // a match in the low address bits alone is not a hit: upper bits must be zero
      if (access && apb_req_i.pwrite && mapped) begin
         unique case (word_addr)
            lai_pkg::ADDR_ENABLE_A: begin
               state_d.enable_a = write_value(apb_req_i.pwdata);
            end
            lai_pkg::ADDR_ENABLE_B: begin
               state_d.enable_b = write_value(apb_req_i.pwdata);
            end
            lai_pkg::ADDR_EDGE_SEL: begin
               state_d.edge_sel = write_value(apb_req_i.pwdata);
            end
            default: begin
            end
         endcase
      end

      // read data captured in the setup cycle so it is a flop at the access edge
      if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) begin
         unique case (word_addr)
            lai_pkg::ADDR_ENABLE_A: state_d.rdata = state_q.enable_a;
            lai_pkg::ADDR_ENABLE_B: state_d.rdata = state_q.enable_b;
            lai_pkg::ADDR_EDGE_SEL: state_d.rdata = state_q.edge_sel;
            lai_pkg::ADDR_STATUS:   state_d.rdata = {1'b0, flags_now};
            default:                state_d.rdata = lai_pkg::RESET_VAL;
         endcase
         // an aliased address must not leak a register value
         if (!mapped) begin
            state_d.rdata = lai_pkg::RESET_VAL;
         end
      end

      // tx clock activity watchdog
      state_d.tx_clk_prev = transmit_clock_input_i;
      if (transmit_clock_input_i != state_q.tx_clk_prev) begin
         state_d.tx_clk_idle   = '0;
         state_d.tx_clk_absent = 1'b0;
      end else if (state_q.tx_clk_idle != lai_pkg::TX_CLK_LOSS_LIMIT) begin
         state_d.tx_clk_idle = state_q.tx_clk_idle + 7'h01;
      end else begin
         state_d.tx_clk_absent = 1'b1;
      end

      // flag transitions, compared against previous sample
      state_d.flags_prev = flags_now;
      state_d.flag_evt.loop_activate_seen_flag = edge_event(
         flags_now.loop_activate_seen_flag, state_q.flags_prev.loop_activate_seen_flag,
         state_q.edge_sel[lai_pkg::BIT_LOOP_ACT], state_q.enable_a[lai_pkg::BIT_LOOP_ACT]);
      state_d.flag_evt.loop_deactivate_seen_flag = edge_event(
         flags_now.loop_deactivate_seen_flag, state_q.flags_prev.loop_deactivate_seen_flag,
         state_q.edge_sel[lai_pkg::BIT_LOOP_DEACT], state_q.enable_a[lai_pkg::BIT_LOOP_DEACT]);
      state_d.flag_evt.pattern_sync_flag = edge_event(
         flags_now.pattern_sync_flag, state_q.flags_prev.pattern_sync_flag,
         state_q.edge_sel[lai_pkg::BIT_PAT_SYNC], state_q.enable_a[lai_pkg::BIT_PAT_SYNC]);
      state_d.flag_evt.tx_clock_absent_flag = edge_event(
         flags_now.tx_clock_absent_flag, state_q.flags_prev.tx_clock_absent_flag,
         state_q.edge_sel[lai_pkg::BIT_TX_CLK], state_q.enable_a[lai_pkg::BIT_TX_CLK]);
      state_d.flag_evt.driver_fault_flag = edge_event(
         flags_now.driver_fault_flag, state_q.flags_prev.driver_fault_flag,
         state_q.edge_sel[lai_pkg::BIT_DRV_FAULT], state_q.enable_a[lai_pkg::BIT_DRV_FAULT]);
      state_d.flag_evt.alarm_indication_flag = edge_event(
         flags_now.alarm_indication_flag, state_q.flags_prev.alarm_indication_flag,
         state_q.edge_sel[lai_pkg::BIT_ALARM_IND], state_q.enable_a[lai_pkg::BIT_ALARM_IND]);
      state_d.flag_evt.rx_signal_absent_flag = edge_event(
         flags_now.rx_signal_absent_flag, state_q.flags_prev.rx_signal_absent_flag,
         state_q.edge_sel[lai_pkg::BIT_SIG_ABSENT],
         state_q.enable_a[lai_pkg::BIT_SIG_ABSENT]);

      // second group: pulses gated straight by enable B, field order matches bits 6..0
      state_d.evt_b = events_b_i & state_q.enable_b[lai_pkg::EVT_B_N-1:0];
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= '0;
      end else if (clk_en_i) begin
         state_q <= state_d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // zero wait states; unmapped addresses answer with pslverr
   always_comb begin
      apb_rsp_o.pready  = 1'b1;
      apb_rsp_o.pslverr = access && !mapped;
      apb_rsp_o.prdata  = {24'h000000, state_q.rdata};
   end

   assign flag_events_o = state_q.flag_evt;
   assign events_b_o    = state_q.evt_b;
   assign any_event_o   = (|state_q.flag_evt) || (|state_q.evt_b);
   assign line_status_o = state_q.flags_prev;

endmodule

`default_nettype wire

// File: lai_checker.sv
// lai_checker: port-level assertions for the line alarm interrupt mask block.
// assumes binding to lai_line_alarm_irq_mask; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module lai_checker (
   // clock, reset and control
   input wire logic                   clock_i,
   input wire logic                   reset_i,
   input wire logic                   clk_en_i,
   input wire logic                   transmit_clock_input_i,
   // apb and event ports
   input wire lai_pkg::lai_apb_req_t  apb_req_i,
   input wire lai_pkg::lai_apb_rsp_t  apb_rsp_o,
   input wire lai_pkg::lai_flags_t    flags_i,
   input wire lai_pkg::lai_events_b_t events_b_i,
   input wire lai_pkg::lai_flags_t    flag_events_o,
   input wire lai_pkg::lai_events_b_t events_b_o,
   input wire logic                   any_event_o,
   input wire lai_pkg::lai_flags_t    line_status_o
);
   // ***************************************************************
   // helper logic
   // ***************************************************************
   logic       tx_q;
   logic [6:0] idle_q;
   logic       mapped;
   assign mapped = apb_req_i.paddr inside {32'hCC, 32'hD0, 32'hD4, 32'hD8};
   // idle count saturates well past the loss limit; frozen with the clock enable
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         tx_q   <= 1'b0;
         idle_q <= 7'h00;
      end else if (clk_en_i) begin
         tx_q <= transmit_clock_input_i;
         if (tx_q != transmit_clock_input_i) idle_q <= 7'h00;
         else if (idle_q != 7'h64) idle_q <= idle_q + 7'h01;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_pready_high: assert property (apb_rsp_o.pready) else $error("pready low");
   a_rdata_upper: assert property (apb_rsp_o.prdata[31:7] == 25'h0) else $error("rdata high");
   a_unmapped_err: assert property (apb_req_i.psel && apb_req_i.penable |->
      apb_rsp_o.pslverr == !mapped) else $error("pslverr wrong");
   a_reset_clear: assert property ($past(reset_i) |-> flag_events_o == 7'h00 &&
      events_b_o == 7'h00 && line_status_o == 7'h00) else $error("reset state");
   a_status_copy: assert property (!$past(reset_i) && $past(clk_en_i) |->
      (line_status_o & 7'h77) == ($past(flags_i) & 7'h77)) else $error("status copy");
   a_events_b_gate: assert property (!$past(reset_i) && $past(clk_en_i) |->
      (events_b_o & ~$past(events_b_i)) == 7'h00) else $error("event b without cause");
   a_flag_event_cause: assert property (!$past(reset_i) && $past(clk_en_i) |->
      (flag_events_o & 7'h77 & ~(line_status_o ^ $past(line_status_o))) == 7'h00)
      else $error("flag event without change");
   a_any_event_or: assert property (any_event_o == (|flag_events_o || |events_b_o))
      else $error("any event mismatch");
   a_tx_idle_low: assert property (idle_q inside {[7'h01:7'h47]} |-> !line_status_o[3])
      else $error("tx absent too early");
   a_tx_idle_high: assert property (idle_q inside {[7'h48:7'h64]} |-> line_status_o[3])
      else $error("tx absent missing");
   c_flag_event: cover property (|flag_events_o);
   c_event_b: cover property (|events_b_o);
   c_tx_absent: cover property (line_status_o[3] && flag_events_o[3]);
endmodule
bind lai_line_alarm_irq_mask lai_checker chk (.clock_i(clock_i), .reset_i(reset_i),
   .clk_en_i(clk_en_i), .transmit_clock_input_i(transmit_clock_input_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .flags_i(flags_i), .events_b_i(events_b_i),
   .flag_events_o(flag_events_o), .events_b_o(events_b_o), .any_event_o(any_event_o),
   .line_status_o(line_status_o));
`default_nettype wire

// File: testbench.sv
// testbench: self-checking bench with an integer model of the mask block.
// assumes package and checker compiled first; bench drives every port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic                   clock_i, reset_i, clk_en_i, txc, any_event_o, er, pen;
   lai_pkg::lai_apb_req_t  req;
   lai_pkg::lai_apb_rsp_t  rsp;
   lai_pkg::lai_flags_t    flags_i, flag_events_o, line_status_o;
   lai_pkg::lai_events_b_t events_b_i, events_b_o;
   int                     n_errors, compares, cyc, ntx;
   logic [31:0]            rd;
   logic [6:0]             ea, eb, es, pf, ppf, pe, x, xb;
   lai_line_alarm_irq_mask uut (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .apb_req_i(req), .apb_rsp_o(rsp), .flags_i(flags_i), .transmit_clock_input_i(txc),
      .events_b_i(events_b_i), .flag_events_o(flag_events_o), .events_b_o(events_b_o),
      .any_event_o(any_event_o), .line_status_o(line_status_o));
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (flag_events_o[3] === 1'b1) ntx++;
      if (cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end
   task conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock_i);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock_i);
      req.penable <= 1'b1;
      do @(posedge clock_i); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
   endtask
   // outputs seen now come from the values driven one step earlier;
   // a low enable at that edge leaves outputs and history untouched
   task step(input logic [6:0] f, input logic [6:0] e, input logic n);
      @(posedge clock_i);
      flags_i <= f;
      events_b_i <= e;
      clk_en_i <= n;
      txc <= ~txc;
      @(negedge clock_i);
      if (pen) begin
         x = ((pf & ~ppf) | ((pf ^ ppf) & es)) & ea & 7'h77;
         xb = pe & eb;
         ppf = pf;
      end
      `CHK(flag_events_o, x)
      `CHK(events_b_o, xb)
      `CHK(any_event_o, |x || |xb)
      `CHK(line_status_o, ppf & 7'h77)
      pf = f;
      pe = e;
      pen = n;
   endtask
   task setup(input logic [6:0] a, input logic [6:0] b, input logic [6:0] s);
      ea = a;
      eb = b;
      es = s;
      apb(1'b1, 32'hCC, {25'h0, a});
      apb(1'b1, 32'hD0, {25'h0, b});
      apb(1'b1, 32'hD4, {25'h0, s});
   endtask
   initial begin
      {clk_en_i, reset_i, txc, req, flags_i, events_b_i} = '0;
      clk_en_i = 1'b1;
      reset_i = 1'b1;
      {n_errors, compares, cyc, ntx} = '0;
      void'($urandom(31249));
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 32'hCC + 32'(4 * i), 32'h0);
         `CHK(rd, 32'h0)
         apb(1'b1, 32'hCC + 32'(4 * i), 32'hFFFF_FFFF);
         apb(1'b0, 32'hCC + 32'(4 * i), 32'h0);
         `CHK(rd, 32'h7F)
      end
      apb(1'b0, 32'h0, 32'h0);
      `CHK({er, rd}, 33'h1_0000_0000)
      apb(1'b1, 32'h4CC, 32'h0);
      `CHK(er, 1'b1)
      apb(1'b0, 32'h4CC, 32'h0);
      `CHK({er, rd}, 33'h1_0000_0000)
      apb(1'b0, 32'hCC, 32'h0);
      `CHK(rd, 32'h7F)
      for (int k = 0; k < 4; k++) begin
         x = 7'($urandom);
         setup(k < 2 ? 7'h7F : k == 2 ? x : 7'h00, k < 2 ? 7'h7F : ~x,
               k == 0 ? 7'h00 : k == 1 ? 7'h7F : 7'($urandom));
         {pf, ppf, pe, pen} = {flags_i, flags_i, events_b_i, 1'b1};
         repeat (50) step(7'($urandom), 7'($urandom), 1'($urandom));
         step(pf, pe, 1'b1);
      end
      ntx = 0;
      setup(7'h08, 7'h00, 7'h08);
      repeat (90) @(posedge clock_i);
      @(negedge clock_i);
      `CHK(line_status_o[3], 1'b1)
      `CHK(ntx, 1)
      @(posedge clock_i);
      txc <= ~txc;
      repeat (5) @(posedge clock_i);
      `CHK(ntx, 2)
      setup(7'h00, 7'h00, 7'h08);
      repeat (90) @(posedge clock_i);
      `CHK(ntx, 2)
      apb(1'b1, 32'hD8, 32'hFF);
      `CHK(er, 1'b0)
      apb(1'b0, 32'hD8, 32'h0);
      `CHK(rd, {25'h0, flags_i & 7'h77 | 7'h08})
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 32'hCC + 32'(4 * i), 32'h0);
         `CHK(rd, 32'h0)
      end
      conclude();
   end
endmodule
`default_nettype wire
